// *** ssr_pkg.sv ***
// Package: register map, field positions and reset values of the sync serial receiver
package ssr_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] SSR_OFF_STATCTL   = 8'h00;
    localparam logic [7:0] SSR_OFF_DATA      = 8'h04;
    localparam logic [7:0] SSR_OFF_BAUD_LO   = 8'h08;
    localparam logic [7:0] SSR_OFF_BAUD_HI   = 8'h0c;
    localparam logic [7:0] SSR_OFF_CONFIG    = 8'h10;
    localparam logic [7:0] SSR_OFF_STATUS    = 8'h14;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    // receive_status_control
    localparam int SSR_BIT_SERIAL_PORT_ENABLE   = 7;
    localparam int SSR_BIT_RX9    = 6;
    localparam int SSR_BIT_SINGLE = 5;
    localparam int SSR_BIT_CONT   = 4;
    localparam int SSR_BIT_ADDRESS_DETECT_ENABLE  = 3;
    localparam int SSR_BIT_FRAME  = 2;
    localparam int SSR_BIT_OVRN   = 1;
    localparam int SSR_BIT_NINTH  = 0;
    // configuration register
    localparam int SSR_BIT_MASTER_CLOCK_SOURCE   = 0;
    localparam int SSR_BIT_RECEIVE_INTERRUPT_ENABLE   = 1;
    localparam int SSR_BIT_HIGH_SPEED_SELECT   = 2;
    localparam int SSR_BIT_WIDE_DIVISOR_SELECT  = 3;
    // status register
    localparam int SSR_BIT_FLAG   = 0;
    localparam int SSR_BIT_CNT    = 1;
    localparam int SSR_BIT_IRQ    = 3;
    localparam int SSR_BIT_BUSY   = 4;

    // ------------------------------------------------------------------
    // Sizes, counts and reset values
    // ------------------------------------------------------------------
    localparam int         SSR_FIFO_DEPTH = 2;
    localparam logic [3:0] SSR_BITS_8     = 4'h8;
    localparam logic [3:0] SSR_BITS_9     = 4'h9;
    localparam int         SSR_SYNC_LEN   = 3;
    localparam logic [7:0] SSR_RST_CTL    = 8'h00;
    localparam logic [15:0] SSR_RST_BAUD  = 16'h0000;

    typedef logic [8:0] ssr_char_t;

endpackage : ssr_pkg

// *** ssr_baud_if.sv ***
// Interface: baud divisor request and bit-clock enable between receiver and divider
`timescale 1ns/1ps
interface ssr_baud_if;
    logic [15:0] divisor;
    logic        run;
    logic        tick;

    modport gen  (input divisor, input run, output tick);
    modport user (output divisor, output run, input tick);
endinterface : ssr_baud_if

// *** ssr_baud.sv ***
// Baud divider: one-cycle enable pulse every divisor+1 clocks while running
`timescale 1ns/1ps
module ssr_baud (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Divider port
    ssr_baud_if.gen   bif
);
    import ssr_pkg::*;

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } ssr_baud_state_t;

    ssr_baud_state_t st_q;
    ssr_baud_state_t st_d;

    always_comb begin
        st_d      = st_q;
        st_d.tick = 1'b0;
        if (!bif.run) begin
            // Restart so the first half period is full length
            st_d.cnt = 16'h0000;
        end else if (st_q.cnt >= bif.divisor) begin
            st_d.cnt  = 16'h0000;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign bif.tick = st_q.tick;

endmodule // ssr_baud

// *** ssr_receiver.sv ***
// Synchronous serial receiver with Wishbone register slave and two-character FIFO
//
// Overview of operation
// [RQ1] Master receive keeps the data pin driver off; pin is input only.
// [RQ2] Reception starts only when single or continuous receive enable is set.
// [RQ3] Single receive alone: master makes exactly one character's worth of clocks.
// [RQ4] Single receive enable clears itself when a character completes.
// [RQ5] Continuous receive: master clocks without pause until the enable clears; code also stops the clock while overrun is set.
// [RQ6] Continuous clear mid-character stops the clock at once, drops partial data.
// [RQ7] Both enables set: single clears after first character, continuous goes on.
// [RQ8] Data pin sampled on trailing clock edge, shifted into the shift register.
// [RQ9] Complete character sets receive flag and enters the two-entry FIFO.
// [RQ10] Data register shows low eight bits of the oldest unread character.
// [RQ11] Receive flag stays set while any unread character remains.
// [RQ12] Slave mode takes the clock from the clock pin, driver off.
// [RQ13] External master changes data on leading edge; one bit per clock.
// [RQ14] External master gives exactly one clock per data bit.
// [RQ15] Third full character with FIFO full sets overrun, FIFO kept intact.
// [RQ16] During overrun stored characters readable, no new characters accepted.
// [RQ17] Overrun under single receive clears on a data register read.
// [RQ18] Overrun under continuous clears when continuous or port enable clears.
// [RQ19] Ninth-bit enable shifts nine bits; ninth bit shown in a status bit.
// [RQ20] Software reads the ninth bit before the low eight bits.
// [RQ21] Software sets divisor, speed, mode, port enable, then one receive enable.
// [RQ22] Receive interrupt request is receive flag and interrupt enable together.
// [RQ23] Status/control bits 7..0: port, ninth, single, cont, addr, frame, overrun, ninth data.
// [RQ24] Reading the data register pops the oldest character from the FIFO.
`timescale 1ns/1ps
module ssr_receiver (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Link pins
    input  wire logic        clock_pin_i,
    output logic             clock_pin_o,
    output logic             clock_pin_oe_o,
    input  wire logic        data_pin_i,
    output logic             data_pin_o,
    output logic             data_pin_oe_o,
    // Receive interrupt request
    output logic             rx_irq_o
);
    import ssr_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        // Software controls and overrun flags
        logic        serial_port_enable;
        logic        ninth_bit_enable;
        logic        single_receive_enable;
        logic        continuous_receive_enable;
        logic        address_detect_enable;
        logic        overrun_error_flag;
        logic        overrun_in_cont;
        logic        master_clock_source;
        logic        receive_interrupt_enable;
        logic        high_speed_select;
        logic        wide_divisor_select;
        logic [7:0]  baud_divisor_low;
        logic [7:0]  baud_divisor_high;
        // Receive engine
        logic [8:0]  receive_shift_reg;
        logic [3:0]  bit_cnt;
        logic        clk_out;
        logic        clk_oe;
        // Pin synchronisers, [0] clock pin, [1] data pin
        logic [1:0][SSR_SYNC_LEN-1:0] sync;
        logic [1:0]  filt;
        logic        clk_prev;
        // FIFO
        logic [SSR_FIFO_DEPTH-1:0][8:0] fifo;
        logic        rd_ptr;
        logic [1:0]  count;
        // Bus answer and interrupt request
        logic        ack;
        logic [31:0] rdata;
        logic        irq;
    } ssr_state_t;

    ssr_state_t st_q;
    ssr_state_t st_d;

    ssr_baud_if baud_bus ();

    ssr_baud u_baud (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .bif   (baud_bus)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr[7:2] == off[7:2]);
    endfunction

    function automatic logic [7:0] statctl(input ssr_state_t s);
        logic [7:0] v;
        v                 = 8'h00;
        v[SSR_BIT_SERIAL_PORT_ENABLE]   = s.serial_port_enable;
        v[SSR_BIT_RX9]    = s.ninth_bit_enable;
        v[SSR_BIT_SINGLE] = s.single_receive_enable;
        v[SSR_BIT_CONT]   = s.continuous_receive_enable;
        v[SSR_BIT_ADDRESS_DETECT_ENABLE]  = s.address_detect_enable;
        v[SSR_BIT_FRAME]  = 1'b0;
        v[SSR_BIT_OVRN]   = s.overrun_error_flag;
        v[SSR_BIT_NINTH]  = s.fifo[s.rd_ptr][8];
        return v;
    endfunction

    logic       bus_req;
    logic       wr_en;
    logic       rd_en;
    logic       pop;
    logic       push;
    logic       running;
    logic       sample;
    logic       cont_cleared;
    logic [3:0] nbits;
    logic [8:0] shifted;
    logic [8:0] new_char;
    logic [7:0] wbyte;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_d         = st_q;
        st_d.ack     = 1'b0;
        bus_req      = cyc_i && stb_i && !st_q.ack;
        wr_en        = bus_req && we_i && sel_i[0];
        rd_en        = bus_req && !we_i;
        wbyte        = dat_i[7:0];
        pop          = 1'b0;
        push         = 1'b0;
        sample       = 1'b0;
        cont_cleared = 1'b0;
        new_char     = 9'h000;
        shifted      = 9'h000;
        nbits        = st_q.ninth_bit_enable ? SSR_BITS_9 : SSR_BITS_8; // [RQ19]

        // Three-stage pin sync; a level counts once stages two and three agree
        for (int i = 0; i < 2; i++) begin
            st_d.sync[i] = {st_q.sync[i][SSR_SYNC_LEN-2:0], (i == 0) ? clock_pin_i : data_pin_i};
            if (st_q.sync[i][1] == st_q.sync[i][2]) begin
                st_d.filt[i] = st_q.sync[i][2];
            end
        end
        st_d.clk_prev = st_q.filt[0];

        // Bus answer, one cycle after the request
        if (bus_req) begin
            st_d.ack   = 1'b1;
            st_d.rdata = 32'h0000_0000;
            if (hit(adr_i, SSR_OFF_STATCTL)) begin
                st_d.rdata[7:0] = statctl(st_q); // [RQ23]
            end else if (hit(adr_i, SSR_OFF_DATA)) begin
                st_d.rdata[7:0] = st_q.fifo[st_q.rd_ptr][7:0]; // [RQ10]
                pop = rd_en && (st_q.count != 2'h0); // [RQ24]
            end else if (hit(adr_i, SSR_OFF_BAUD_LO)) begin
                st_d.rdata[7:0] = st_q.baud_divisor_low;
            end else if (hit(adr_i, SSR_OFF_BAUD_HI)) begin
                st_d.rdata[7:0] = st_q.baud_divisor_high;
            end else if (hit(adr_i, SSR_OFF_CONFIG)) begin
                st_d.rdata[SSR_BIT_MASTER_CLOCK_SOURCE]  = st_q.master_clock_source;
                st_d.rdata[SSR_BIT_RECEIVE_INTERRUPT_ENABLE]  = st_q.receive_interrupt_enable;
                st_d.rdata[SSR_BIT_HIGH_SPEED_SELECT]  = st_q.high_speed_select;
                st_d.rdata[SSR_BIT_WIDE_DIVISOR_SELECT] = st_q.wide_divisor_select;
            end else if (hit(adr_i, SSR_OFF_STATUS)) begin
                st_d.rdata[SSR_BIT_FLAG]             = (st_q.count != 2'h0);
                st_d.rdata[SSR_BIT_CNT+1:SSR_BIT_CNT] = st_q.count;
                st_d.rdata[SSR_BIT_IRQ]              = st_q.irq;
                st_d.rdata[SSR_BIT_BUSY]             = (st_q.bit_cnt != 4'h0);
            end
        end

        // Register writes
        if (wr_en) begin
            if (hit(adr_i, SSR_OFF_STATCTL)) begin
                st_d.serial_port_enable        = wbyte[SSR_BIT_SERIAL_PORT_ENABLE];
                st_d.ninth_bit_enable          = wbyte[SSR_BIT_RX9];
                st_d.single_receive_enable     = wbyte[SSR_BIT_SINGLE];
                st_d.continuous_receive_enable = wbyte[SSR_BIT_CONT];
                st_d.address_detect_enable     = wbyte[SSR_BIT_ADDRESS_DETECT_ENABLE];
                cont_cleared = st_q.continuous_receive_enable && !wbyte[SSR_BIT_CONT];
            end else if (hit(adr_i, SSR_OFF_BAUD_LO)) begin
                st_d.baud_divisor_low = wbyte;
            end else if (hit(adr_i, SSR_OFF_BAUD_HI)) begin
                st_d.baud_divisor_high = wbyte;
            end else if (hit(adr_i, SSR_OFF_CONFIG)) begin
                st_d.master_clock_source      = wbyte[SSR_BIT_MASTER_CLOCK_SOURCE];
                st_d.receive_interrupt_enable = wbyte[SSR_BIT_RECEIVE_INTERRUPT_ENABLE];
                st_d.high_speed_select        = wbyte[SSR_BIT_HIGH_SPEED_SELECT];
                st_d.wide_divisor_select      = wbyte[SSR_BIT_WIDE_DIVISOR_SELECT];
            end
        end

        // Overrun clearing, applied before new events so a set wins
        if (st_q.overrun_error_flag) begin
            if (pop && !st_q.overrun_in_cont) begin
                st_d.overrun_error_flag = 1'b0; // [RQ17]
            end
            if (cont_cleared && st_q.overrun_in_cont) begin
                st_d.overrun_error_flag = 1'b0; // [RQ18]
            end
        end

        // FIFO pop
        if (pop) begin
            st_d.rd_ptr = !st_q.rd_ptr;
            st_d.count  = st_q.count - 2'h1;
        end

        // Receive engine runs on the new control values
        running = st_d.serial_port_enable && !st_q.overrun_error_flag
                  && (st_d.single_receive_enable || st_d.continuous_receive_enable); // [RQ2] [RQ16]

        if (!running) begin
            // Stop at once and drop any partial character
            st_d.clk_out  = 1'b0; // [RQ6]
            st_d.bit_cnt  = 4'h0;
        end else if (st_d.master_clock_source) begin
            if (baud_bus.tick) begin
                st_d.clk_out = !st_q.clk_out; // [RQ5]
                sample       = st_q.clk_out; // [RQ8]
            end
        end else begin
            sample = st_q.clk_prev && !st_q.filt[0]; // [RQ12]
        end

        if (sample) begin
            shifted                = {st_q.filt[1], st_q.receive_shift_reg[8:1]}; // [RQ8]
            st_d.receive_shift_reg = shifted;
            st_d.bit_cnt           = st_q.bit_cnt + 4'h1;
            if (st_q.bit_cnt + 4'h1 == nbits) begin
                st_d.bit_cnt = 4'h0;
                new_char     = st_d.ninth_bit_enable ? shifted : {1'b0, shifted[8:1]};
                // One character done: single enable drops, continuous takes over
                st_d.single_receive_enable = 1'b0; // [RQ3] [RQ4] [RQ7]
                if (st_d.count == 2'(SSR_FIFO_DEPTH)) begin
                    st_d.overrun_error_flag = 1'b1; // [RQ15]
                    st_d.overrun_in_cont    = st_d.continuous_receive_enable;
                end else begin
                    push = 1'b1; // [RQ9]
                end
            end
        end

        if (push) begin
            st_d.fifo[st_d.rd_ptr ^ st_d.count[0]] = new_char;
            st_d.count = st_d.count + 2'h1; // [RQ11]
        end

        // Clearing the port enable resets the receive path
        if (!st_d.serial_port_enable) begin
            st_d.overrun_error_flag = 1'b0; // [RQ18]
            st_d.count              = 2'h0;
            st_d.rd_ptr             = 1'b0;
            st_d.bit_cnt            = 4'h0;
            st_d.clk_out            = 1'b0;
        end

        // Clock pin driven only as master; data pin never driven here
        st_d.clk_oe = st_d.serial_port_enable && st_d.master_clock_source; // [RQ12]
        st_d.irq    = (st_d.count != 2'h0) && st_d.receive_interrupt_enable; // [RQ22]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Divider request
    // ------------------------------------------------------------------
    // Narrow divisor mode ignores the high byte
    assign baud_bus.divisor = st_q.wide_divisor_select
                            ? {st_q.baud_divisor_high, st_q.baud_divisor_low}
                            : {8'h00, st_q.baud_divisor_low};
    assign baud_bus.run     = st_q.serial_port_enable && st_q.master_clock_source
                            && !st_q.overrun_error_flag
                            && (st_q.single_receive_enable || st_q.continuous_receive_enable);

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign dat_o          = st_q.rdata;
    assign ack_o          = st_q.ack;
    assign clock_pin_o    = st_q.clk_out;
    assign clock_pin_oe_o = st_q.clk_oe;
    assign data_pin_o     = st_q.address_detect_enable & 1'b0;
    assign data_pin_oe_o  = st_q.high_speed_select & 1'b0; // [RQ1]
    assign rx_irq_o       = st_q.irq;

endmodule // ssr_receiver

// *** ssr_link_model.sv ***
// Far-side serial device model: feeds the data line, makes the clock in slave mode
`timescale 1ns/1ps
module ssr_link_model (
    // Clock and pattern load
    input  wire logic        clk_i,
    input  wire logic        ld_i,
    input  wire logic [31:0] pat_i,
    // Link wires
    input  wire logic        ck_i,
    output logic             ck_o,
    output logic             dt_o
);
    logic [31:0] pat_q;
    logic        ck_q;
    logic        own_q;
    initial begin
        ck_o = 1'b0;
        dt_o = 1'b0;
        own_q = 1'b0;
        ck_q = 1'b0;
        pat_q = 32'h0;
    end
    // Hold time ends at the trailing edge, so the line is turned over there
    always @(posedge clk_i) begin
        ck_q <= ck_i;
        if (ld_i) begin
            pat_q <= pat_i;
        end else if (!own_q && ck_i && !ck_q) begin
            dt_o <= pat_q[0];
            pat_q <= pat_q >> 1;
        end else if (!own_q && !ck_i && ck_q) begin
            dt_o <= ~dt_o;
        end
    end
    // Slave-mode master: clock stands still low outside the frame
    task automatic send(input int n);
        own_q = 1'b1;
        #3.3;
        for (int i = 0; i < n; i++) begin
            ck_o = 1'b1;
            dt_o = pat_q[0];
            pat_q = pat_q >> 1;
            #62.5;
            ck_o = 1'b0;
            #62.5;
        end
        // Last bit must outlast the receiver's pin sync before the line lets go
        #62.5;
        dt_o = ~dt_o;
        own_q = 1'b0;
    endtask
endmodule // ssr_link_model

// *** ssr_receiver_assertions.sv ***
// Checker: port-level properties of the sync serial receiver
`timescale 1ns/1ps
module ssr_receiver_assertions
    import ssr_pkg::*;
(
    // Clock, reset and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // Link and interrupt
    input wire logic        clock_pin_i,
    input wire logic        clock_pin_o,
    input wire logic        clock_pin_oe_o,
    input wire logic        data_pin_i,
    input wire logic        data_pin_o,
    input wire logic        data_pin_oe_o,
    input wire logic        rx_irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic       take, wctl, mst, one_q, ck_q;
    logic [7:0] ctl_q, cfg_q;
    logic [3:0] cnt_q, lim_q;
    assign take = cyc_i && stb_i && !ack_o;
    assign wctl = take && we_i && sel_i[0] && adr_i == SSR_OFF_STATCTL;
    assign mst  = ctl_q[SSR_BIT_SERIAL_PORT_ENABLE] && cfg_q[SSR_BIT_MASTER_CLOCK_SOURCE];
    // Shadow of the written controls; rises counted since the last control write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_q <= 8'h0;
            cfg_q <= 8'h0;
            cnt_q <= 4'h0;
            lim_q <= 4'h0;
            one_q <= 1'b0;
            ck_q  <= 1'b0;
        end else begin
            ck_q <= clock_pin_o;
            if (take && we_i && sel_i[0] && adr_i == SSR_OFF_CONFIG) cfg_q <= dat_i[7:0];
            if (wctl) begin
                ctl_q <= dat_i[7:0];
                one_q <= dat_i[SSR_BIT_SINGLE] && !dat_i[SSR_BIT_CONT];
                lim_q <= dat_i[SSR_BIT_RX9] ? SSR_BITS_9 : SSR_BITS_8;
                cnt_q <= 4'h0;
            end else if (clock_pin_o && !ck_q && cnt_q != 4'hf) begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
    sequence s_rx_off;
        wctl && dat_i[SSR_BIT_SINGLE] == 1'b0 && dat_i[SSR_BIT_CONT] == 1'b0;
    endsequence
    sequence s_quiet;
        (!clock_pin_o) [*8];
    endsequence
    ack_answer_a: assert property (take |=> ack_o) else $error("no ack after request");
    ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    unmapped_read_a: assert property (take && !we_i && adr_i == 8'hfc |=> dat_o == 32'h0)
        else $error("unmapped read not zero");
    data_drv_a: assert property (!data_pin_oe_o && !data_pin_o)
        else $error("data pin driven");
    clock_oe_a: assert property (1 ##1 $stable(mst) |-> clock_pin_oe_o == mst)
        else $error("clock driver enable wrong");
    clock_drive_a: assert property ($rose(clock_pin_o) |-> clock_pin_oe_o)
        else $error("clock toggles undriven");
    single_count_a: assert property (one_q |-> cnt_q <= lim_q)
        else $error("too many clocks for single receive");
    stop_clock_a: assert property (s_rx_off |-> ##[1:3] s_quiet)
        else $error("clock runs after receive off");
    irq_mask_a: assert property (!cfg_q[SSR_BIT_RECEIVE_INTERRUPT_ENABLE] ##1 !cfg_q[SSR_BIT_RECEIVE_INTERRUPT_ENABLE] |-> !rx_irq_o)
        else $error("irq while disabled");
endmodule // ssr_receiver_assertions

// *** ssr_receiver_tb.sv ***
// Testbench: register-level receive scenarios for the sync serial receiver
`timescale 1ns/1ps
module ssr_receiver_tb;
    import ssr_pkg::*;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
    logic [7:0]  adr_i, rd;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, pat;
    logic        ck_o, ck_oe, dt_o, dt_oe, irq, m_ck, m_dt, ld, ck_w, dt_w;
    int          n_errors, checked;
    // Wire levels from the receiver's driver enables, else the model
    assign ck_w = ck_oe ? ck_o : m_ck;
    assign dt_w = dt_oe ? dt_o : m_dt;
    ssr_receiver DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .clock_pin_i(ck_w), .clock_pin_o(ck_o), .clock_pin_oe_o(ck_oe),
        .data_pin_i(dt_w), .data_pin_o(dt_o), .data_pin_oe_o(dt_oe), .rx_irq_o(irq));
    ssr_link_model u_mdl (.clk_i(clk_i), .ld_i(ld), .pat_i(pat), .ck_i(ck_w),
        .ck_o(m_ck), .dt_o(m_dt));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic end_sim();
        $display("Checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Classic cycle: hold until ack is sampled, then release for a cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] s);
        int i;
        i = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            i++;
        end while (ack_o !== 1'b1 && i < 20);
        if (ack_o !== 1'b1) begin
            n_errors++;
            end_sim();
        end
        rd = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d, 4'h1);
    endtask
    task automatic rdr(input logic [7:0] a);
        wb(1'b0, a, 8'h0, 4'h1);
    endtask
    task automatic wait_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
        for (int i = 0; i < 400; i++) begin
            rdr(a);
            if ((rd & m) === v) return;
        end
        n_errors++;
        end_sim();
    endtask
    task automatic load(input logic [31:0] p);
        pat <= p;
        ld  <= 1'b1;
        @(posedge clk_i);
        ld  <= 1'b0;
        @(posedge clk_i);
    endtask
    initial begin
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, ld, pat} = '0;
        rst_i = 1'b1;
        n_errors = 0;
        checked = 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdr(SSR_OFF_STATCTL); check("ctl_rst", rd, SSR_RST_CTL);
        wb(1'b1, SSR_OFF_CONFIG, 8'h03, 4'h0);
        rdr(SSR_OFF_CONFIG); check("cfg_sel", rd, 8'h00);
        rdr(8'hfc); check("unmapped", rd, 8'h00);
        wr(SSR_OFF_BAUD_LO, 8'h07);
        wr(SSR_OFF_CONFIG, 8'h0b);
        rdr(SSR_OFF_CONFIG);
        check("cfg", rd, 8'h0b);
        wr(SSR_OFF_STATCTL, 8'h80);
        load(32'h0000_00a5);
        repeat (100) @(posedge clk_i);
        rdr(SSR_OFF_STATUS); check("idle", rd, 8'h00);
        wr(SSR_OFF_STATCTL, 8'ha0);
        wait_reg(SSR_OFF_STATUS, 8'h06, 8'h02);
        rdr(SSR_OFF_STATCTL); check("single_clr", rd, 8'h80);
        rdr(SSR_OFF_STATUS); check("status1", rd, 8'h0b);
        check("irq_on", {7'h0, irq}, 8'h01);
        rdr(SSR_OFF_DATA); check("char", rd, 8'ha5);
        rdr(SSR_OFF_STATUS); check("empty", rd, 8'h00);
        // Three singles against a two-deep store
        load(32'h005a_c33c);
        for (int k = 1; k <= 2; k++) begin
            wr(SSR_OFF_STATCTL, 8'ha0);
            wait_reg(SSR_OFF_STATUS, 8'h06, {5'h0, k[1:0], 1'b0});
        end
        wr(SSR_OFF_CONFIG, 8'h01);
        check("irq_mask", {7'h0, irq}, 8'h00);
        wr(SSR_OFF_CONFIG, 8'h03);
        wr(SSR_OFF_STATCTL, 8'ha0);
        wait_reg(SSR_OFF_STATCTL, 8'h02, 8'h02);
        rdr(SSR_OFF_STATUS); check("full", rd, 8'h0d);
        rdr(SSR_OFF_DATA); check("old0", rd, 8'h3c);
        rdr(SSR_OFF_STATCTL); check("ovr_rd", rd & 8'h02, 8'h00);
        rdr(SSR_OFF_DATA); check("old1", rd, 8'hc3);
        // Port enable low flushes the unit
        wr(SSR_OFF_STATCTL, 8'h00);
        wr(SSR_OFF_STATCTL, 8'h80);
        load(32'h0000_6996);
        wr(SSR_OFF_STATCTL, 8'hb0);
        wait_reg(SSR_OFF_STATUS, 8'h06, 8'h04);
        rdr(SSR_OFF_STATCTL); check("both", rd & 8'h30, 8'h10);
        wait_reg(SSR_OFF_STATCTL, 8'h02, 8'h02);
        wr(SSR_OFF_STATCTL, 8'h80);
        rdr(SSR_OFF_STATCTL); check("ovr_cont", rd, 8'h80);
        rdr(SSR_OFF_DATA); check("c0", rd, 8'h96);
        rdr(SSR_OFF_DATA); check("c1", rd, 8'h69);
        wr(SSR_OFF_STATCTL, 8'h90);
        repeat (60) @(posedge clk_i);
        wr(SSR_OFF_STATCTL, 8'h80);
        repeat (300) @(posedge clk_i);
        rdr(SSR_OFF_STATUS); check("partial", rd, 8'h00);
        load(32'h0000_014b);
        wr(SSR_OFF_STATCTL, 8'he0);
        wait_reg(SSR_OFF_STATUS, 8'h06, 8'h02);
        rdr(SSR_OFF_STATCTL); check("ninth", rd, 8'hc1);
        rdr(SSR_OFF_DATA); check("low8", rd, 8'h4b);
        // Slave mode: far side makes the clock
        wr(SSR_OFF_CONFIG, 8'h02);
        check("ck_oe", {7'h0, ck_oe}, 8'h00);
        load(32'h0000_007e);
        wr(SSR_OFF_STATCTL, 8'ha0);
        u_mdl.send(8);
        @(posedge clk_i);
        wait_reg(SSR_OFF_STATUS, 8'h06, 8'h02);
        rdr(SSR_OFF_DATA); check("slave", rd, 8'h7e);
        end_sim();
    end
endmodule // ssr_receiver_tb
bind ssr_receiver ssr_receiver_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .clock_pin_i(clock_pin_i),
    .clock_pin_o(clock_pin_o), .clock_pin_oe_o(clock_pin_oe_o), .data_pin_i(data_pin_i),
    .data_pin_o(data_pin_o), .data_pin_oe_o(data_pin_oe_o), .rx_irq_o(rx_irq_o));
